/* File: core/pst_regs.sv */
`timescale 1ns/10ps
`default_nettype none
`include "pst_cfg.svh"

module pst_regs import pst_pkg::*; #(
	parameter int RECOVER_STEP_CYC = `PST_RECOVER_STEP_US * `PST_CLK_MHZ,
	parameter int OCP_TIMEOUT_CYC = `PST_OCP_TIMEOUT_US * `PST_CLK_MHZ
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic [6:0] smbus_addr,
	input wire pst_flags_t flags_in,
	input wire logic power_enable_req,
	output logic nvm_rd_en,
	output logic [15:0] nvm_rd_addr,
	input wire logic [7:0] nvm_rd_data,
	input wire logic nvm_prog_req,
	input wire logic [15:0] nvm_prog_addr,
	output logic nvm_prog_permit,
	output logic boot_done,
	output pst_cal_t cal_out,
	output logic [7:0] rev_off_mv,
	output logic [7:0] rev_on_mv,
	output logic [4:0] curr_limit_trim,
	output logic [2:0] share_window,
	output logic [7:0] share_offset,
	output logic [6:0] share_slope,
	output logic [6:0] region_locks,
	output logic power_enable_out,
	output logic soft_start_enable,
	output logic load_ov_recovering
);

	pst_flags_t flags_m, flags_s;
	logic [6:0] addr_m, addr_s;
	pst_cal_t cal_reg;
	logic [7:0] limit_reg, offset_reg;
	logic [6:0] slope_reg, lock_reg;
	pst_boot_t boot_state;
	logic [4:0] boot_idx, cap_idx;
	logic cap_valid, wr_strobe, host_wr, ld_en, ocp_timed_out, load_ov_prev;
	logic [7:0] reg_ptr, wr_data, rd_data, ld_addr, ld_val;
	logic [15:0] ocp_cnt, rec_cnt;
	pst_status_t status_now;

	// ==========================================================
	// synchronisers for analog flags and address straps
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flags_m <= '0;
			flags_s <= '0;
			addr_m <= 7'h00;
			addr_s <= 7'h00;
		end else begin
			flags_m <= flags_in;
			flags_s <= flags_m;
			addr_m <= smbus_addr;
			addr_s <= addr_m;
		end
	end

	pst_smbus_slave pst_smbus_slave_inst (
		.clk(clk),
		.rst(rst),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.sda_oe(sda_oe),
		.dev_addr(addr_s),
		.reg_ptr(reg_ptr),
		.rd_data(rd_data),
		.wr_strobe(wr_strobe),
		.wr_data(wr_data)
	);

	// open drain: only ever pulls low
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sda_out <= 1'b0;
		end else begin
			sda_out <= 1'b0;
		end
	end

	// ==========================================================
	// boot download
	// boot block fetch
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			boot_state <= PST_BOOT_FETCH;
			boot_idx <= 5'h00;
			nvm_rd_en <= 1'b0;
			nvm_rd_addr <= 16'h0000;
			cap_valid <= 1'b0;
			cap_idx <= 5'h00;
			boot_done <= 1'b0;
		end else begin
			cap_valid <= nvm_rd_en;
			cap_idx <= nvm_rd_addr[4:0];
			case (boot_state)
				PST_BOOT_FETCH: begin
					nvm_rd_en <= 1'b1;
					nvm_rd_addr <= `PST_BOOT_BASE | {11'h000, boot_idx};
					boot_idx <= boot_idx + 5'h01;
					if (boot_idx == `PST_BOOT_LAST_IDX) begin
						boot_state <= PST_BOOT_LAST;
					end
				end
				PST_BOOT_LAST: begin
					nvm_rd_en <= 1'b0;
					if (cap_valid && cap_idx == `PST_BOOT_LAST_IDX) begin
						boot_state <= PST_BOOT_RUN;
						boot_done <= 1'b1;
					end
				end
				PST_BOOT_RUN: nvm_rd_en <= 1'b0;
				default: boot_state <= PST_BOOT_FETCH;
			endcase
		end
	end

	// host writes during boot are dropped so the nvm image wins
	assign host_wr = wr_strobe && boot_state == PST_BOOT_RUN;

	always_comb begin
		ld_en = cap_valid | host_wr;
		ld_addr = cap_valid ? {3'h0, cap_idx} : reg_ptr;
		ld_val = cap_valid ? nvm_rd_data : wr_data;
	end

	// ==========================================================
	// trim and configuration registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cal_reg <= `PST_CAL_RESET;
			limit_reg <= `PST_LIMIT_RESET;
			offset_reg <= `PST_OFFSET_RESET;
			slope_reg <= `PST_SLOPE_RESET;
			lock_reg <= `PST_LOCK_RESET;
		end else if (ld_en) begin
			case (ld_addr)
				`PST_ADDR_CAL: cal_reg <= ld_val;
				`PST_ADDR_LIMIT: limit_reg <= ld_val;
				`PST_ADDR_OFFSET: offset_reg <= ld_val;
				`PST_ADDR_SLOPE: slope_reg <= ld_val[7:1];
				`PST_ADDR_LOCKS: lock_reg <= ld_val[6:0] | `PST_FACTORY_MASK;
				default: lock_reg <= lock_reg;
			endcase
		end
	end

	// ==========================================================
	// status assembly and read path
	always_comb begin
		status_now.fault_monitor = {flags_s.ov_fault, flags_s.uv_fault,
			ocp_timed_out, flags_s.monitor_flags};
		status_now.share_supply = flags_s.share_supply;
		status_now.pin_overcurrent = {flags_s.ac_sense, flags_s.power_on_req,
			flags_s.power_enable_state, flags_s.power_on_link,
			flags_s.dc_good_state,
			flags_s.overcurrent,
			flags_s.pulses_seen, flags_s.fault_latch};
		case (reg_ptr)
			`PST_ADDR_FAULT_MON: rd_data = status_now.fault_monitor;
			`PST_ADDR_SHARE_SUP: rd_data = status_now.share_supply;
			`PST_ADDR_PIN_OC: rd_data = status_now.pin_overcurrent;
			`PST_ADDR_CAL: rd_data = cal_reg;
			`PST_ADDR_LIMIT: rd_data = limit_reg;
			`PST_ADDR_OFFSET: rd_data = offset_reg;
			`PST_ADDR_SLOPE: rd_data = {slope_reg, 1'b0};
			`PST_ADDR_LOCKS: rd_data = {1'b0, lock_reg};
			default: rd_data = 8'h00;
		endcase
	end

	// ==========================================================
	// overcurrent timeout; the raw comparator bit bypasses this
	// persistence timer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ocp_cnt <= 16'h0000;
			ocp_timed_out <= 1'b0;
		end else if (!flags_s.overcurrent) begin
			ocp_cnt <= 16'h0000;
			ocp_timed_out <= 1'b0;
		end else if (!ocp_timed_out) begin
			ocp_cnt <= ocp_cnt + 16'h0001;
			ocp_timed_out <= ocp_cnt == 16'(OCP_TIMEOUT_CYC - 1);
		end
	end

	// ==========================================================
	// load overvoltage recovery delay
	// recovery countdown
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			load_ov_prev <= 1'b0;
			rec_cnt <= 16'h0000;
			load_ov_recovering <= 1'b0;
		end else begin
			load_ov_prev <= flags_s.load_ov;
			if (load_ov_prev && !flags_s.load_ov) begin
				rec_cnt <= 16'(RECOVER_STEP_CYC) *
					(16'(cal_reg.recover_sel) + 16'h0001);
				load_ov_recovering <= 1'b1;
			end else begin
				if (rec_cnt != 16'h0000) begin
					rec_cnt <= rec_cnt - 16'h0001;
				end
				load_ov_recovering <= flags_s.load_ov || rec_cnt > 16'h0001;
			end
		end
	end

	// ==========================================================
	// trim outputs and gating
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cal_out <= `PST_CAL_RESET;
			rev_off_mv <= `PST_REV_OFF_BASE_MV;
			rev_on_mv <= `PST_REV_ON_BASE_MV;
			curr_limit_trim <= 5'h00;
			share_window <= 3'h0;
			share_offset <= 8'h00;
			share_slope <= 7'h00;
			region_locks <= `PST_LOCK_RESET;
			power_enable_out <= 1'b0;
			soft_start_enable <= 1'b0;
		end else begin
			cal_out <= cal_reg;
			rev_off_mv <= `PST_REV_OFF_BASE_MV +
				8'(cal_reg.rev_off_sel) * `PST_REV_OFF_STEP_MV;
			rev_on_mv <= `PST_REV_ON_BASE_MV +
				8'(cal_reg.rev_on_sel) * `PST_REV_ON_STEP_MV;
			curr_limit_trim <= limit_reg[7:3];
			share_window <= limit_reg[2:0];
			share_offset <= offset_reg;
			share_slope <= slope_reg;
			region_locks <= lock_reg;
			power_enable_out <= power_enable_req &&
				(!cal_reg.gate_enable || flags_s.ac_sense);
			soft_start_enable <= !cal_reg.gate_ramp || flags_s.ac_sense;
		end
	end

	// ==========================================================
	// nvm write protection
	function automatic logic region_locked(input logic [15:0] a,
		input logic [6:0] lk);
		logic hit;
		hit = 1'b0;
		if (a >= `PST_NVM_BASE && a < `PST_NVM_BOOT_REGION) begin
			hit = lk[a[7:6]];
		end else if (a >= `PST_NVM_BOOT_REGION &&
			a < `PST_NVM_FACTORY_REGION) begin
			hit = lk[4];
		end else if (a >= `PST_NVM_FACTORY_REGION && a < `PST_NVM_REGION_SIX) begin
			hit = lk[5];
		end else if (a >= `PST_NVM_REGION_SIX && a < `PST_NVM_LOCK_END) begin
			hit = lk[6];
		end
		return hit;
	endfunction : region_locked

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			nvm_prog_permit <= 1'b0;
		end else begin
			nvm_prog_permit <= nvm_prog_req &&
				!region_locked(nvm_prog_addr, lock_reg);
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_fault_mon_read: assert property (
		reg_ptr == `PST_ADDR_FAULT_MON |-> rd_data[7:6] ==
		{flags_s.ov_fault, flags_s.uv_fault}
		&& rd_data[4:0] == flags_s.monitor_flags)
		else $error("fault monitor status wrong");
	a_ocp_persist: assert property (
		$rose(ocp_timed_out) |-> $past(flags_s.overcurrent, 2)
		&& $past(ocp_cnt) == 16'(OCP_TIMEOUT_CYC - 1))
		else $error("ocp timeout set early");
	a_share_read: assert property (
		reg_ptr == `PST_ADDR_SHARE_SUP |-> rd_data == flags_s.share_supply)
		else $error("share status wrong");
	a_pin_mirror: assert property (
		reg_ptr == `PST_ADDR_PIN_OC |-> rd_data[7] == flags_s.ac_sense
		&& rd_data[3] == flags_s.dc_good_state)
		else $error("pin mirror wrong");
	a_ocp_direct: assert property (
		reg_ptr == `PST_ADDR_PIN_OC && flags_s.overcurrent |-> rd_data[2])
		else $error("raw overcurrent not shown");
	a_pulse_fault: assert property (
		reg_ptr == `PST_ADDR_PIN_OC |-> rd_data[1:0] ==
		{flags_s.pulses_seen, flags_s.fault_latch})
		else $error("pulse or fault bit wrong");
	a_rev_thresh: assert property (
		##1 rev_off_mv == 8'h64 + 8'h32 * 8'($past(cal_reg.rev_off_sel)))
		else $error("turn-off threshold wrong");
	a_gate_enable: assert property (
		cal_reg.gate_enable && !flags_s.ac_sense |=> !power_enable_out)
		else $error("enable not gated");
	a_gate_ramp: assert property (
		cal_reg.gate_ramp && !flags_s.ac_sense |=> !soft_start_enable)
		else $error("ramp not held");
	a_recover_hold: assert property (
		// four cycles: the shortest hold that a reduced step still gives
		$fell(flags_s.load_ov) |=> load_ov_recovering [*4])
		else $error("recovery delay cut short");
	a_slope_drop: assert property (
		host_wr && reg_ptr == `PST_ADDR_SLOPE |=> slope_reg ==
		$past(wr_data[7:1]))
		else $error("slope write wrong");
	a_lock_block: assert property (
		nvm_prog_req && lock_reg[4] && nvm_prog_addr[15:5] == 11'h408
		|=> !nvm_prog_permit)
		else $error("boot region write allowed");
	a_factory_lock: assert property (
		lock_reg[5])
		else $error("factory lock cleared");
	a_boot_len: assert property (
		$rose(boot_done) |-> $past(cap_idx) == 5'h1f && $past(cap_valid))
		else $error("boot ended early");
	a_status_ro: assert property (
		host_wr && reg_ptr <= `PST_ADDR_PIN_OC |=> $stable(cal_reg)
		&& $stable(lock_reg) && $stable(offset_reg))
		else $error("status write had effect");

	c_boot: cover property ($rose(boot_done));
	c_host_write: cover property (host_wr && reg_ptr == `PST_ADDR_CAL);
	c_ocp_timeout: cover property ($rose(ocp_timed_out));
	c_recover_end: cover property ($fell(load_ov_recovering));

endmodule : pst_regs

`default_nettype wire

/* File: include/pst_cfg.svh */
`ifndef PST_CFG_SVH
`define PST_CFG_SVH

// ==========================================================
// register offsets
`define PST_ADDR_FAULT_MON 8'h00
`define PST_ADDR_SHARE_SUP 8'h01
`define PST_ADDR_PIN_OC 8'h02
`define PST_ADDR_CAL 8'h03
`define PST_ADDR_LIMIT 8'h04
`define PST_ADDR_OFFSET 8'h05
`define PST_ADDR_SLOPE 8'h06
`define PST_ADDR_LOCKS 8'h07

// ==========================================================
// reset values and boot block
`define PST_CAL_RESET 8'h00
`define PST_LIMIT_RESET 8'h00
`define PST_OFFSET_RESET 8'h00
`define PST_SLOPE_RESET 7'h00
`define PST_LOCK_RESET 7'h20
`define PST_FACTORY_MASK 7'h20
`define PST_BOOT_BASE 16'h8100
`define PST_BOOT_LAST_IDX 5'h1f

// ==========================================================
// nvm protection regions
`define PST_NVM_BASE 16'h8000
`define PST_NVM_BOOT_REGION 16'h8100
`define PST_NVM_FACTORY_REGION 16'h8120
`define PST_NVM_REGION_SIX 16'h8140
`define PST_NVM_LOCK_END 16'h8180

// ==========================================================
// thresholds in mV
`define PST_REV_OFF_BASE_MV 8'h64
`define PST_REV_OFF_STEP_MV 8'h32
`define PST_REV_ON_BASE_MV 8'h14
`define PST_REV_ON_STEP_MV 8'h0a

// ==========================================================
// timing
`define PST_CLK_MHZ 20
`define PST_RECOVER_STEP_US 100
`define PST_OCP_TIMEOUT_US 10

`endif

/* File: include/pst_pkg.sv */
package pst_pkg;

	// ==========================================================
	// analog flag inputs, one bit per comparator or pin
	typedef struct packed {
		logic ov_fault;
		logic uv_fault;
		logic [4:0] monitor_flags;
		logic [7:0] share_supply;
		logic ac_sense;
		logic power_on_req;
		logic power_enable_state;
		logic power_on_link;
		logic dc_good_state;
		logic overcurrent;
		logic pulses_seen;
		logic fault_latch;
		logic load_ov;
	} pst_flags_t;

	typedef struct packed {
		logic [1:0] rev_off_sel;
		logic [1:0] rev_on_sel;
		logic gate_enable;
		logic gate_ramp;
		logic [1:0] recover_sel;
	} pst_cal_t;

	typedef struct packed {
		logic [7:0] fault_monitor;
		logic [7:0] share_supply;
		logic [7:0] pin_overcurrent;
	} pst_status_t;

	typedef enum logic [2:0] {
		PST_BOOT_FETCH = 3'b001,
		PST_BOOT_LAST = 3'b010,
		PST_BOOT_RUN = 3'b100
	} pst_boot_t;

	typedef enum logic [4:0] {
		PST_BUS_IDLE = 5'b00001,
		PST_BUS_RX = 5'b00010,
		PST_BUS_ACK = 5'b00100,
		PST_BUS_TX = 5'b01000,
		PST_BUS_TXACK = 5'b10000
	} pst_bus_t;

	typedef enum logic [2:0] {
		PST_PH_ADDR = 3'b001,
		PST_PH_CMD = 3'b010,
		PST_PH_DATA = 3'b100
	} pst_phase_t;

endpackage : pst_pkg

/* File: core/pst_smbus_slave.sv */
`timescale 1ns/10ps
`default_nettype none

module pst_smbus_slave import pst_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_oe,
	input wire logic [6:0] dev_addr,
	output logic [7:0] reg_ptr,
	input wire logic [7:0] rd_data,
	output logic wr_strobe,
	output logic [7:0] wr_data
);

	logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
	logic scl_rise, scl_fall, bus_start, bus_stop, rw;
	logic [3:0] bit_cnt;
	logic [7:0] shreg;
	pst_bus_t state;
	pst_phase_t phase;

	// ==========================================================
	// pin synchronisers, first stage feeds only the second
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			{scl_m, scl_s, scl_d} <= 3'h7;
			{sda_m, sda_s, sda_d} <= 3'h7;
		end else begin
			{scl_m, scl_s, scl_d} <= {scl_in, scl_m, scl_s};
			{sda_m, sda_s, sda_d} <= {sda_in, sda_m, sda_s};
		end
	end

	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
	assign bus_stop = scl_s & scl_d & ~sda_d & sda_s;

	// ==========================================================
	// byte engine: address, command pointer, then data bytes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= PST_BUS_IDLE;
			phase <= PST_PH_ADDR;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			rw <= 1'b0;
			sda_oe <= 1'b0;
			reg_ptr <= 8'h00;
			wr_strobe <= 1'b0;
			wr_data <= 8'h00;
		end else begin
			wr_strobe <= 1'b0;
			if (bus_start) begin
				state <= PST_BUS_RX;
				phase <= PST_PH_ADDR;
				bit_cnt <= 4'h0;
				sda_oe <= 1'b0;
			end else if (bus_stop) begin
				state <= PST_BUS_IDLE;
				sda_oe <= 1'b0;
			end else begin
				case (state)
					PST_BUS_RX: begin
						if (scl_rise) begin
							shreg <= {shreg[6:0], sda_s};
							bit_cnt <= bit_cnt + 4'h1;
						end else if (scl_fall && bit_cnt == 4'h8) begin
							bit_cnt <= 4'h0;
							state <= PST_BUS_ACK;
							sda_oe <= 1'b1;
							case (phase)
								PST_PH_ADDR: begin
									rw <= shreg[0];
									// not our address: stay off the bus
									if (shreg[7:1] != dev_addr) begin
										state <= PST_BUS_IDLE;
										sda_oe <= 1'b0;
									end
								end
								PST_PH_CMD: reg_ptr <= shreg;
								default: begin
									wr_strobe <= 1'b1;
									wr_data <= shreg;
								end
							endcase
						end
					end
					PST_BUS_ACK: begin
						if (scl_fall) begin
							if (phase == PST_PH_ADDR && rw) begin
								state <= PST_BUS_TX;
								shreg <= rd_data;
								sda_oe <= ~rd_data[7];
							end else begin
								state <= PST_BUS_RX;
								sda_oe <= 1'b0;
								if (phase == PST_PH_DATA) begin
									reg_ptr <= reg_ptr + 8'h01;
								end
								phase <= (phase == PST_PH_ADDR) ?
									PST_PH_CMD : PST_PH_DATA;
							end
						end
					end
					PST_BUS_TX: begin
						if (scl_fall) begin
							if (bit_cnt == 4'h7) begin
								bit_cnt <= 4'h0;
								sda_oe <= 1'b0;
								state <= PST_BUS_TXACK;
								reg_ptr <= reg_ptr + 8'h01;
							end else begin
								sda_oe <= ~shreg[6];
								shreg <= {shreg[6:0], 1'b0};
								bit_cnt <= bit_cnt + 4'h1;
							end
						end
					end
					PST_BUS_TXACK: begin
						// a nack ends the read; wait for stop
						if (scl_rise && sda_s) begin
							state <= PST_BUS_IDLE;
						end else if (scl_fall) begin
							state <= PST_BUS_TX;
							shreg <= rd_data;
							sda_oe <= ~rd_data[7];
						end
					end
					default: state <= PST_BUS_IDLE;
				endcase
			end
		end
	end

endmodule : pst_smbus_slave

`default_nettype wire

/* File: sim/pst_host.sv */
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// smbus host: drives scl and an open-drain sda request
module pst_host (
	input wire logic clk,
	input wire logic sda_in,
	output logic scl,
	output logic sda
);
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end

	task automatic wait_n(input int n);
		repeat (n) @(posedge clk);
		#5;
	endtask : wait_n

	// sda moves two clocks into the low phase so that the slave's
	// synchroniser never sees it change together with scl
	task automatic start_cond();
		wait_n(2);
		sda = 1'b1;
		wait_n(6);
		scl = 1'b1;
		wait_n(6);
		sda = 1'b0;
		wait_n(6);
		scl = 1'b0;
	endtask : start_cond

	task automatic stop_cond();
		wait_n(2);
		sda = 1'b0;
		wait_n(6);
		scl = 1'b1;
		wait_n(6);
		sda = 1'b1;
		wait_n(6);
	endtask : stop_cond

	task automatic xfer(input logic [7:0] d, input logic m_ack,
		output logic [7:0] q, output logic s_ack);
		logic [8:0] v;
		v = {d, m_ack};
		for (int i = 8; i >= 0; i--) begin
			wait_n(2);
			sda = v[i];
			wait_n(4);
			scl = 1'b1;
			wait_n(6);
			v[i] = sda_in;
			scl = 1'b0;
		end
		{q, s_ack} = v;
	endtask : xfer

	task automatic write_reg(input logic [6:0] a, input logic [7:0] r,
		input logic [7:0] d, output logic ok);
		logic [7:0] q;
		logic [2:0] k;
		start_cond();
		xfer({a, 1'b0}, 1'b1, q, k[0]);
		xfer(r, 1'b1, q, k[1]);
		xfer(d, 1'b1, q, k[2]);
		stop_cond();
		ok = (k === 3'b000);
	endtask : write_reg

	task automatic read_reg(input logic [6:0] a, input logic [7:0] r,
		output logic [7:0] d, output logic ok);
		logic [7:0] q;
		logic [3:0] k;
		start_cond();
		xfer({a, 1'b0}, 1'b1, q, k[0]);
		xfer(r, 1'b1, q, k[1]);
		start_cond();
		xfer({a, 1'b1}, 1'b1, q, k[2]);
		xfer(8'hff, 1'b1, d, k[3]);
		stop_cond();
		ok = (k[2:0] === 3'b000);
	endtask : read_reg
endmodule : pst_host

`default_nettype wire

/* File: sim/test_psu_status_trim_registers.sv */
`timescale 1ns/10ps
`default_nettype none

module test_psu_status_trim_registers import pst_pkg::*; ;
	localparam logic [6:0] dev_addr = 7'h2a;
	logic clk, rst, sda_line, host_scl, host_sda, sda_oe, ok;
	logic nvm_rd_en, nvm_prog_req, nvm_prog_permit, boot_done;
	logic pe_req, pe_out, ss_en, ov_rec;
	logic [15:0] nvm_rd_addr, nvm_prog_addr;
	logic [7:0] nvm_rd_data, off_mv, on_mv, offset, q;
	logic [6:0] slope, locks;
	logic [4:0] limit;
	logic [2:0] window;
	pst_flags_t flags;
	pst_cal_t cal_out;
	int error_cnt, checks_done;
	logic [7:0] boot_img [5] = '{8'h9e, 8'h5b, 8'h3c, 8'ha5, 8'h81};
	logic [23:0] pat [2] = '{24'hacb564, 24'h534a92};
	logic [23:0] sexp [2] = '{24'h965ab2, 24'h49a549};
	logic [15:0] top_addr [7] = '{16'h803f, 16'h807f, 16'h80bf,
		16'h80ff, 16'h811f, 16'h813f, 16'h817f};

	// released sda reads high through the pull-up
	assign sda_line = host_sda & ~sda_oe;

	pst_regs #(.RECOVER_STEP_CYC(4), .OCP_TIMEOUT_CYC(5)) pst_regs_inst (
		.clk(clk), .rst(rst), .scl_in(host_scl), .sda_in(sda_line),
		.sda_out(), .sda_oe(sda_oe), .smbus_addr(dev_addr),
		.flags_in(flags), .power_enable_req(pe_req),
		.nvm_rd_en(nvm_rd_en), .nvm_rd_addr(nvm_rd_addr),
		.nvm_rd_data(nvm_rd_data), .nvm_prog_req(nvm_prog_req),
		.nvm_prog_addr(nvm_prog_addr), .nvm_prog_permit(nvm_prog_permit),
		.boot_done(boot_done), .cal_out(cal_out), .rev_off_mv(off_mv),
		.rev_on_mv(on_mv), .curr_limit_trim(limit), .share_window(window),
		.share_offset(offset), .share_slope(slope), .region_locks(locks),
		.power_enable_out(pe_out), .soft_start_enable(ss_en),
		.load_ov_recovering(ov_rec)
	);

	pst_host pst_host_inst (.clk(clk), .sda_in(sda_line), .scl(host_scl),
		.sda(host_sda));

	// ==========================================================
	// clock, watchdog and boot memory
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	initial begin
		repeat (60000) @(posedge clk);
		error_cnt++;
		final_report();
	end

	// one-cycle latency; outside the boot image the bus shows junk
	always @(posedge clk) begin : nvm_model
		logic [15:0] a;
		logic e;
		a = nvm_rd_addr;
		e = nvm_rd_en;
		#5;
		if (e && a[4:0] >= 5'h03 && a[4:0] <= 5'h07)
			nvm_rd_data = boot_img[a[4:0] - 5'h03];
		else
			nvm_rd_data = ~a[7:0];
	end

	// ==========================================================
	// helpers
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic final_report();
		if (error_cnt == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#5;
	endtask : tick

	task automatic wr(input logic [7:0] r, input logic [7:0] d);
		logic k;
		pst_host_inst.write_reg(dev_addr, r, d, k);
		check(k, 1'b1);
	endtask : wr

	task automatic rd(input logic [7:0] r, output logic [7:0] d);
		logic k;
		pst_host_inst.read_reg(dev_addr, r, d, k);
		check(k, 1'b1);
	endtask : rd

	task automatic perm(input logic [15:0] a, input logic e);
		nvm_prog_addr = a;
		nvm_prog_req = 1'b1;
		tick(1);
		check(nvm_prog_permit, e);
		nvm_prog_req = 1'b0;
		tick(1);
	endtask : perm

	// ==========================================================
	// test sequence
	initial begin
		int w, w0;
		logic [7:0] c;
		logic [6:0] eff;
		rst = 1'b1;
		flags = '0;
		pe_req = 1'b0;
		nvm_prog_req = 1'b0;
		nvm_prog_addr = 16'h0000;
		repeat (20) @(posedge clk);
		#5;
		rst = 1'b0;
		for (int i = 0; i < 100 && boot_done !== 1'b1; i++) tick(1);
		tick(3);
		check(boot_done, 1'b1);
		check(cal_out, boot_img[0]);
		check(locks, boot_img[4][6:0] | 7'h20);
		for (int r = 3; r < 8; r++) begin
			c = (r == 6) ? 8'hfe : (r == 7) ? 8'h7f : 8'hff;
			rd(8'(r), q);
			check(q & c, (boot_img[r - 3] | {2'h0, r == 7, 5'h00}) & c);
		end
		for (int p = 0; p < 2; p++) begin
			flags = pat[p];
			tick(4);
			for (int r = 0; r < 3; r++) wr(8'(r), ~sexp[p][23 - 8 * r -: 8]);
			for (int r = 0; r < 3; r++) begin
				rd(8'(r), q);
				check(q, sexp[p][23 - 8 * r -: 8]);
			end
		end
		// a spike shorter than the timeout must not show
		flags.overcurrent = 1'b1;
		tick(3);
		flags.overcurrent = 1'b0;
		tick(6);
		rd(8'h00, q);
		check(q[5], 1'b0);
		flags.overcurrent = 1'b1;
		tick(12);
		rd(8'h00, q);
		check(q[5], 1'b1);
		rd(8'h02, q);
		check(q[2], 1'b1);
		flags.overcurrent = 1'b0;
		pe_req = 1'b1;
		for (int s = 0; s < 4; s++) begin
			c = {s[1:0], s[1:0], s[0], s[1], s[1:0]};
			wr(8'h03, c);
			tick(3);
			check(off_mv, 8'h64 + 8'h32 * 8'(s));
			check(on_mv, 8'h14 + 8'h0a * 8'(s));
			check(pe_out, !s[0]);
			check(ss_en, !s[1]);
			flags.load_ov = 1'b1;
			w = 0;
			for (int k = 0; k < 60; k++) begin
				tick(1);
				if (k == 2) flags.load_ov = 1'b0;
				w += (ov_rec === 1'b1);
			end
			if (s == 0) w0 = w;
			// width difference cancels the fixed sync latency
			check(8'(w - w0), 8'(4 * s));
		end
		flags.ac_sense = 1'b1;
		tick(4);
		check(pe_out, 1'b1);
		check(ss_en, 1'b1);
		wr(8'h04, 8'hc4);
		wr(8'h05, 8'hff);
		wr(8'h06, 8'h5b);
		tick(3);
		check(limit, 5'h18);
		check(window, 3'h4);
		check(offset, 8'hff);
		check(slope, 7'h2d);
		wr(8'h05, 8'h00);
		tick(3);
		check(offset, 8'h00);
		for (int v = 0; v < 2; v++) begin
			c = v ? 8'hd1 : 8'h00;
			wr(8'h07, c);
			tick(3);
			eff = c[6:0] | 7'h20;
			check(locks, eff);
			for (int i = 0; i < 7; i++) perm(top_addr[i], !eff[i]);
			perm(16'h8180, 1'b1);
		end
		rd(8'h08, q);
		check(q, 8'h00);
		pst_host_inst.read_reg(7'h15, 8'h00, q, ok);
		check(ok, 1'b0);
		final_report();
	end
endmodule : test_psu_status_trim_registers

`default_nettype wire
